/* File: verilog/vme_powerup_regs.vh */
// vme_powerup_regs.vh: offsets, field positions, reset values and timing for the
// power-up strap configuration block.
// assumes: included by bare name; holds definitions only, no logic.
`ifndef VME_POWERUP_REGS_VH
`define VME_POWERUP_REGS_VH

// apb byte offsets, one aligned 32-bit word each
`define OFS_GENERAL_CONTROL   8'h00
`define OFS_VME_CONTROL       8'h04
`define OFS_CRCSR_BIT_SET     8'h08
`define OFS_CRCSR_BIT_CLEAR   8'h0c
`define OFS_CRCSR_ATTRIBUTE   8'h10
`define OFS_CRCSR_BASE        8'h14
`define OFS_STRAP_STATUS      8'h18

// general control register fields
`define BIT_SYSFAIL_ENABLE    0
`define BIT_BOARD_FAIL_SW     1
// vme control register field
`define BIT_AUTOSLOT_FAIL     0
// crcsr bit set / bit clear register field
`define BIT_SYSFAIL_SETCLR    0
// crcsr attribute register field
`define BIT_CRCSR_ENABLE      0
// crcsr base register field, bits 7 to 3
`define BASE_MSB              7
`define BASE_LSB              3
// strap status register fields
`define STS_STRAP_LSB         0
`define STS_STRAP_MSB         3
`define BIT_STS_SYSCON        4
`define BIT_STS_AUTO_MODE     5
`define BIT_STS_GEO_MODE      6
`define BIT_STS_ILLEGAL       7
`define BIT_STS_IRQ2          8
`define BIT_STS_BOARD_FAIL    9
`define BIT_STS_CAPTURED      10

// strap bit positions on the four low data lines
`define STRAP_SYSFAIL_RV      0
`define STRAP_AUTOCLEAR       1
`define STRAP_AUTOSLOT        2
`define STRAP_GEO             3

// reset values
`define RST_STRAPS            4'h0
`define RST_BASE              5'h00
`define RST_PINS_IDLE         15'h7e00

// timing: auto-clear delay after system reset, clock period
`define AUTOCLEAR_TIME_NS     1000000
`define MCLK_PERIOD_PS        25000

`endif

/* File: verilog/strap_sync.v */
// strap_sync: two-flop synchroniser for a group of pins from outside mclk.
// assumes: each bit is an independent level; the group is not coherent word data.
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         mclk,
    input  wire         rst_b,
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync
);

    reg [W-1:0] meta_ff;    // first stage, read only by the second stage
    reg [W-1:0] sync_ff;    // second stage, safe for logic

    // both stages reset to the idle pin level so no false edge shows after reset
    always @(posedge mclk) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule
`default_nettype wire

/* File: verilog/strap_decode.v */
// strap_decode: turns the held strap code and the geographic-address test into
// the addressing mode and the reset values applied on every system reset.
// assumes: inputs are stable held values; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "vme_powerup_regs.vh"

module strap_decode (
    input  wire [3:0] strap,
    input  wire       ga_all_high,
    output wire       auto_mode,
    output wire       geo_mode,
    output wire       illegal,
    output wire       crcsr_en_rv,
    output wire       autoslot_fail_rv,
    output wire       sysfail_en_rv,
    output wire       autoclear_sel
);

    wire asid = strap[`STRAP_AUTOSLOT];     // auto slot id requested
    wire gsid = strap[`STRAP_GEO];          // geographic slot id requested

    // codes 01x1 and 11x1 are not allowed; treat them as crcsr disabled
    assign illegal = asid & strap[`STRAP_SYSFAIL_RV];
    // 01x0 always, 11x0 only when every geographic pin reads high
    assign auto_mode = asid & ~illegal & (~gsid | ga_all_high);
    // 10xx always, 11x0 when the geographic pins are not all high
    assign geo_mode = gsid & ~illegal & ~(asid & ga_all_high);
    assign crcsr_en_rv = geo_mode;
    assign autoslot_fail_rv = auto_mode;
    // enable reset value only for disabled or geographic codes ending in one
    assign sysfail_en_rv = strap[`STRAP_SYSFAIL_RV] & ~asid;
    assign autoclear_sel = auto_mode & strap[`STRAP_AUTOCLEAR];

endmodule
`default_nettype wire

/* File: verilog/vme_powerup_option_config.v */
// vme_powerup_option_config: vmebus power-up strap capture and the system-fail,
// crcsr enable/base and system-controller state that follow from it, with an
// apb register slave.
// assumes: all pins arrive asynchronously to mclk; apb master is on mclk.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vme_powerup_regs.vh"

module vme_powerup_option_config #(
    parameter AUTOCLEAR_CYCLES = (`AUTOCLEAR_TIME_NS * 1000) / `MCLK_PERIOD_PS,
    parameter CNT_W            = 16
) (
    input  wire        mclk,
    input  wire        rst_b,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // board pins, all asynchronous
    input  wire        powerup_reset_input_b,
    input  wire        system_reset_input_b,
    input  wire [3:0]  vd_strap,
    input  wire [4:0]  geo_addr_b,
    input  wire        syscon_enable_strap_b,
    input  wire        syscon_disable_strap_b,
    input  wire        grant3_daisy_input_b,
    input  wire        board_fail_input_b,
    // outputs
    output wire        sysfail_output,
    output wire        transceiver_enable_output_b,
    output wire        system_controller_function,
    output wire        crcsr_enable,
    output wire [4:0]  crcsr_base_bits,
    output wire        irq2_request
);

    // ---------------- pin synchronisation ----------------
    wire [14:0] pins_raw;       // all asynchronous pins as one group
    wire [14:0] pins_s;         // after two flops
    assign pins_raw = {powerup_reset_input_b, system_reset_input_b, syscon_enable_strap_b,
                       syscon_disable_strap_b, grant3_daisy_input_b, board_fail_input_b,
                       geo_addr_b, vd_strap};

    strap_sync #(
        .W       (15),
        .RST_VAL (`RST_PINS_IDLE)
    ) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .pin_in   (pins_raw),
        .pin_sync (pins_s)
    );

    wire       pur_s      = pins_s[14];     // power-up reset, low asserted
    wire       srst_s     = pins_s[13];     // system reset, low asserted
    wire       system_controller_function_en_s  = pins_s[12];
    wire       system_controller_function_dis_s = pins_s[11];
    wire       bg3_s      = pins_s[10];
    wire       board_fail_input_s   = pins_s[9];
    wire [4:0] ga_s       = pins_s[8:4];
    wire [3:0] vd_s       = pins_s[3:0];

    // ---------------- edge detection ----------------
    reg  pur_prev_ff;           // previous synchronised power-up reset
    reg  srst_prev_ff;          // previous synchronised system reset
    reg  pur_load_ff;           // power-up release seen last cycle, straps now held
    wire pur_rise  = pur_s & ~pur_prev_ff;      // power-up reset negation
    wire srst_rise = srst_s & ~srst_prev_ff;    // system reset negation

    always @(posedge mclk) begin
        if (!rst_b) begin
            pur_prev_ff  <= 1'b1;
            srst_prev_ff <= 1'b1;
            pur_load_ff  <= 1'b0;
        end else begin
            pur_prev_ff  <= pur_s;
            srst_prev_ff <= srst_s;
            pur_load_ff  <= pur_rise;
        end
    end

    // ---------------- strap capture ----------------
    reg [3:0] strap_ff;         // held strap code
    reg       ga_high_ff;       // geographic pins all high at capture
    reg [4:0] base_rv_ff;       // base reset value, bits 7 to 3
    reg       syscon_ff;        // system controller enabled
    reg       captured_ff;      // a power-up release has been seen

    // the synchroniser delays straps and reset alike, so the edge sees the
    // levels that stood at the pin edge; nothing resamples until next power-up
    always @(posedge mclk) begin
        if (!rst_b) begin
            strap_ff    <= `RST_STRAPS;
            ga_high_ff  <= 1'b0;
            base_rv_ff  <= `RST_BASE;
            syscon_ff   <= 1'b0;
            captured_ff <= 1'b0;
        end else if (pur_rise) begin
            strap_ff    <= vd_s;
            ga_high_ff  <= &ga_s;
            captured_ff <= 1'b1;
            if (vd_s[`STRAP_GEO])
                base_rv_ff <= ~ga_s;
            else
                base_rv_ff <= `RST_BASE;
            case ({system_controller_function_en_s, system_controller_function_dis_s})
                2'b01:   syscon_ff <= 1'b1;
                2'b11:   syscon_ff <= ~bg3_s;
                default: syscon_ff <= 1'b0;
            endcase
        end
    end

    // ---------------- mode decode ----------------
    wire auto_mode;
    wire geo_mode;
    wire illegal;
    wire crcsr_en_rv;
    wire ai_rv;
    wire sfen_rv;
    wire autoclear_sel;

    strap_decode u_decode (
        .strap            (strap_ff),
        .ga_all_high      (ga_high_ff),
        .auto_mode        (auto_mode),
        .geo_mode         (geo_mode),
        .illegal          (illegal),
        .crcsr_en_rv      (crcsr_en_rv),
        .autoslot_fail_rv (ai_rv),
        .sysfail_en_rv    (sfen_rv),
        .autoclear_sel    (autoclear_sel)
    );

    // reload happens while system reset is held and once just after power-up
    // release; the extra cycle lets the decode see the freshly held straps
    wire reload = ~srst_s | pur_load_ff;

    // ---------------- apb access decode ----------------
    reg  [31:0] prdata_ff;      // read data for the access phase
    reg         pready_ff;      // one access-phase cycle, no extra waits
    reg         pslverr_ff;     // unmapped address
    wire        wr_en = psel & penable & pready_ff & pwrite;    // write commits here

    // one-hot style decode shared by read and write paths
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `OFS_GENERAL_CONTROL) | hit(a, `OFS_VME_CONTROL) |
                     hit(a, `OFS_CRCSR_BIT_SET) | hit(a, `OFS_CRCSR_BIT_CLEAR) |
                     hit(a, `OFS_CRCSR_ATTRIBUTE) | hit(a, `OFS_CRCSR_BASE) |
                     hit(a, `OFS_STRAP_STATUS);
        end
    endfunction

    wire wr_general_control_reg = wr_en & hit(paddr, `OFS_GENERAL_CONTROL);
    wire wr_vme_control_reg = wr_en & hit(paddr, `OFS_VME_CONTROL);
    wire wr_bset  = wr_en & hit(paddr, `OFS_CRCSR_BIT_SET);
    wire wr_bclr  = wr_en & hit(paddr, `OFS_CRCSR_BIT_CLEAR);
    wire wr_crcsr_attribute_reg  = wr_en & hit(paddr, `OFS_CRCSR_ATTRIBUTE);
    wire wr_base  = wr_en & hit(paddr, `OFS_CRCSR_BASE);

    // ---------------- control state ----------------
    reg       sfen_ff;          // sysfail_enable_bit
    reg       ai_ff;            // autoslot_fail_bit
    reg       board_fail_sw_bit_ff;         // board_fail_sw_bit
    reg       crcsr_en_ff;      // crcsr enable
    reg [4:0] base_ff;          // crcsr_base_bits
    reg       irq2_ff;          // level two interrupt request
    reg       timer_run_ff;     // autoclear delay counting
    reg [CNT_W-1:0] timer_ff;   // autoclear delay counter

    wire timer_done = timer_run_ff & (timer_ff == AUTOCLEAR_CYCLES[CNT_W-1:0] - 1'b1);

    // system-fail enable: one bit behind three register views; reset reload wins
    always @(posedge mclk) begin
        if (!rst_b) begin
            sfen_ff <= 1'b0;
        end else if (reload) begin
            sfen_ff <= sfen_rv;
        end else if (wr_bset & pwdata[`BIT_SYSFAIL_SETCLR]) begin
            sfen_ff <= 1'b1;
        end else if (wr_bclr & pwdata[`BIT_SYSFAIL_SETCLR]) begin
            sfen_ff <= 1'b0;
        end else if (wr_general_control_reg) begin
            sfen_ff <= pwdata[`BIT_SYSFAIL_ENABLE];
        end
    end

    // auto-slot fail bit: the hardware auto-clear beats a software write in the same cycle
    always @(posedge mclk) begin
        if (!rst_b) begin
            ai_ff <= 1'b0;
        end else if (reload) begin
            ai_ff <= ai_rv;
        end else if (timer_done & autoclear_sel) begin
            ai_ff <= 1'b0;
        end else if (wr_vme_control_reg) begin
            ai_ff <= pwdata[`BIT_AUTOSLOT_FAIL];
        end
    end

    // software board-fail bit; system reset clears it
    always @(posedge mclk) begin
        if (!rst_b) begin
            board_fail_sw_bit_ff <= 1'b0;
        end else if (reload) begin
            board_fail_sw_bit_ff <= 1'b0;
        end else if (wr_general_control_reg) begin
            board_fail_sw_bit_ff <= pwdata[`BIT_BOARD_FAIL_SW];
        end
    end

    // crcsr enable and base: reloaded from strap-derived values on system reset
    always @(posedge mclk) begin
        if (!rst_b) begin
            crcsr_en_ff <= 1'b0;
            base_ff     <= `RST_BASE;
        end else if (reload) begin
            crcsr_en_ff <= crcsr_en_rv;
            base_ff     <= base_rv_ff;
        end else begin
            if (wr_crcsr_attribute_reg)
                crcsr_en_ff <= pwdata[`BIT_CRCSR_ENABLE];
            if (wr_base)
                base_ff <= pwdata[`BASE_MSB:`BASE_LSB];
        end
    end

    // level two request after system reset in auto slot mode, dropped once the
    // monarch programs the base register; base is zero until then
    always @(posedge mclk) begin
        if (!rst_b) begin
            irq2_ff <= 1'b0;
        end else if (reload) begin
            irq2_ff <= 1'b0;
        end else if (srst_rise & auto_mode) begin
            irq2_ff <= 1'b1;
        end else if (wr_base) begin
            irq2_ff <= 1'b0;
        end
    end

    // autoclear delay, counted from system reset negation
    always @(posedge mclk) begin
        if (!rst_b) begin
            timer_run_ff <= 1'b0;
            timer_ff     <= {CNT_W{1'b0}};
        end else if (reload) begin
            timer_run_ff <= 1'b0;
            timer_ff     <= {CNT_W{1'b0}};
        end else if (srst_rise & autoclear_sel) begin
            timer_run_ff <= 1'b1;
            timer_ff     <= {CNT_W{1'b0}};
        end else if (timer_done) begin
            timer_run_ff <= 1'b0;
        end else if (timer_run_ff) begin
            timer_ff <= timer_ff + 1'b1;
        end
    end

    // ---------------- system fail output ----------------
    reg  sysfail_ff;            // drives the open system-fail line, high = asserted
    wire board_fail = board_fail_sw_bit_ff | ~board_fail_input_s;

    // in auto slot mode the fail bit holds the line until it clears; the
    // enable path still applies once software enables it after assignment
    always @(posedge mclk) begin
        if (!rst_b) begin
            sysfail_ff <= 1'b0;
        end else if (auto_mode) begin
            sysfail_ff <= ai_ff | (board_fail & sfen_ff);
        end else begin
            sysfail_ff <= board_fail & sfen_ff;
        end
    end

    // ---------------- transceiver enable ----------------
    reg transceiver_enable_output_b_ff;              // high keeps transceivers off for strap pulls

    always @(posedge mclk) begin
        if (!rst_b)
            transceiver_enable_output_b_ff <= 1'b1;
        else
            transceiver_enable_output_b_ff <= ~pur_s;
    end

    // ---------------- apb slave ----------------
    reg [31:0] nxt_prdata;      // read mux

    always @* begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `OFS_GENERAL_CONTROL: begin
                nxt_prdata[`BIT_SYSFAIL_ENABLE] = sfen_ff;
                nxt_prdata[`BIT_BOARD_FAIL_SW]  = board_fail_sw_bit_ff;
            end
            `OFS_VME_CONTROL: begin
                nxt_prdata[`BIT_AUTOSLOT_FAIL] = ai_ff;
            end
            `OFS_CRCSR_BIT_SET,
            `OFS_CRCSR_BIT_CLEAR: begin
                nxt_prdata[`BIT_SYSFAIL_SETCLR] = sfen_ff;
            end
            `OFS_CRCSR_ATTRIBUTE: begin
                nxt_prdata[`BIT_CRCSR_ENABLE] = crcsr_en_ff;
            end
            `OFS_CRCSR_BASE: begin
                nxt_prdata[`BASE_MSB:`BASE_LSB] = base_ff;
            end
            `OFS_STRAP_STATUS: begin
                nxt_prdata[`STS_STRAP_MSB:`STS_STRAP_LSB] = strap_ff;
                nxt_prdata[`BIT_STS_SYSCON]     = syscon_ff;
                nxt_prdata[`BIT_STS_AUTO_MODE]  = auto_mode;
                nxt_prdata[`BIT_STS_GEO_MODE]   = geo_mode;
                nxt_prdata[`BIT_STS_ILLEGAL]    = illegal;
                nxt_prdata[`BIT_STS_IRQ2]       = irq2_ff;
                nxt_prdata[`BIT_STS_BOARD_FAIL] = board_fail;
                nxt_prdata[`BIT_STS_CAPTURED]   = captured_ff;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    // answer in the first access cycle: ready raised off the setup cycle
    always @(posedge mclk) begin
        if (!rst_b) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~mapped(paddr);
            if (psel & ~penable & ~pwrite)
                prdata_ff <= nxt_prdata;
            else
                prdata_ff <= 32'h0000_0000;
        end
    end

    assign prdata                      = prdata_ff;
    assign pready                      = pready_ff;
    assign pslverr                     = pslverr_ff;
    assign sysfail_output              = sysfail_ff;
    assign transceiver_enable_output_b = transceiver_enable_output_b_ff;
    assign system_controller_function  = syscon_ff;
    assign crcsr_enable                = crcsr_en_ff;
    assign crcsr_base_bits             = base_ff;
    assign irq2_request                = irq2_ff;

endmodule
`default_nettype wire

/* File: verif/vme_powerup_option_config_sva.sv */
// checker: apb answer timing, transceiver enable and crcsr state at the block's ports.
// assumes: bound onto the block; every input is one of its ports.
`timescale 1ns/1ps
`default_nettype none
`include "vme_powerup_regs.vh"
module vme_powerup_option_config_sva (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        powerup_reset_input_b,
    input wire logic        system_reset_input_b,
    input wire logic        transceiver_enable_output_b,
    input wire logic        crcsr_enable,
    input wire logic [4:0]  crcsr_base_bits,
    input wire logic        irq2_request
);
    logic [7:0] wd_ff; // write data of the previous cycle
    logic       wr_ok; // write completing while system reset is off
    // keep last write data so the register can be compared a cycle later
    always @(posedge mclk) begin
        wd_ff <= pwdata[7:0];
    end
    assign wr_ok = psel && penable && pready && pwrite && system_reset_input_b;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_xcvr_off; !powerup_reset_input_b [*4] |=> transceiver_enable_output_b; endproperty
    a_xcvr_off: assert property (p_xcvr_off) else $error("transceivers on during power-up reset");
    property p_xcvr_on; powerup_reset_input_b [*4] |=> !transceiver_enable_output_b; endproperty
    a_xcvr_on: assert property (p_xcvr_on) else $error("transceivers stay off after power-up reset");
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready in first access cycle");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error response malformed");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access cycle");
    property p_base_wr; wr_ok && paddr == `OFS_CRCSR_BASE |=> crcsr_base_bits == wd_ff[7:3] && !irq2_request; endproperty
    a_base_wr: assert property (p_base_wr) else $error("base write not taken");
    property p_hold; (!system_reset_input_b && powerup_reset_input_b) [*6] |=> $stable(crcsr_enable) && $stable(crcsr_base_bits); endproperty
    a_hold: assert property (p_hold) else $error("crcsr state moves in system reset");
endmodule
bind vme_powerup_option_config vme_powerup_option_config_sva u_sva (.mclk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .powerup_reset_input_b, .system_reset_input_b,
    .transceiver_enable_output_b, .crcsr_enable, .crcsr_base_bits, .irq2_request);
`default_nettype wire

/* File: verif/vme_backplane_model.sv */
// backplane model: board pull resistors and live bus traffic on the strap data lines.
// assumes: the bench picks the pulled code; the block drives the transceiver enable.
`timescale 1ns/1ps
`default_nettype none
module vme_backplane_model (
    input  wire logic       mclk,
    input  wire logic [3:0] pull_code,
    input  wire logic       transceiver_enable_output_b,
    output logic      [3:0] vd_strap
);
    logic [3:0] traffic_ff = 4'h5; // bus data once transceivers are on
    // traffic moves every cycle so a late capture cannot see the pulls by luck
    always @(posedge mclk) begin
        traffic_ff <= traffic_ff + 4'h3;
    end
    // pulls set the lines only while the transceivers are off
    assign vd_strap = transceiver_enable_output_b ? pull_code : traffic_ff;
endmodule
`default_nettype wire

/* File: verif/test_vme_powerup_option_config.sv */
// bench: power-up straps, system reset and apb register traffic around the strap block.
// assumes: the backplane model owns the strap lines; autoclear shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "vme_powerup_regs.vh"
module test_vme_powerup_option_config;
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sysfail_output, transceiver_enable_output_b, system_controller_function;
    logic crcsr_enable, irq2_request;
    logic [4:0] crcsr_base_bits, geo_addr_b = 5'h1f;
    logic [3:0] vd_strap, pull_code = 4'h0;
    logic powerup_reset_input_b = 1'b0, system_reset_input_b = 1'b1, board_fail_input_b = 1'b1;
    logic syscon_enable_strap_b = 1'b1, syscon_disable_strap_b = 1'b1, grant3_daisy_input_b = 1'b1;
    int n_fail = 0, total_checks = 0;
    always #12.5 mclk = ~mclk;
    vme_backplane_model u_bp (.mclk, .pull_code, .transceiver_enable_output_b, .vd_strap);
    vme_powerup_option_config #(.AUTOCLEAR_CYCLES(20)) u_dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .powerup_reset_input_b, .system_reset_input_b, .vd_strap,
        .geo_addr_b, .syscon_enable_strap_b, .syscon_disable_strap_b, .grant3_daisy_input_b,
        .board_fail_input_b, .sysfail_output, .transceiver_enable_output_b, .system_controller_function,
        .crcsr_enable, .crcsr_base_bits, .irq2_request);
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one transfer; an idle cycle after it keeps two setups off the same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // straps stay put well before and after the release edge; only legal codes are pulled
    task automatic powerup(input logic [3:0] c, input logic [4:0] g, input logic [2:0] sc);
        powerup_reset_input_b <= 1'b0;
        pull_code <= c;
        geo_addr_b <= g;
        {syscon_enable_strap_b, syscon_disable_strap_b, grant3_daisy_input_b} <= sc;
        tick(8);
        powerup_reset_input_b <= 1'b1;
        tick(8);
    endtask
    task automatic sysrst;
        system_reset_input_b <= 1'b0;
        tick(8);
        system_reset_input_b <= 1'b1;
        tick(6);
    endtask
    task automatic t_geo;
        powerup(4'b1001, 5'b01010, 3'b011);
        check(32'(crcsr_enable), 32'h1);
        check(32'(crcsr_base_bits), 32'h15);
        apb(1'b0, `OFS_GENERAL_CONTROL, 32'h0);
        check(rd, 32'h1);
        board_fail_input_b <= 1'b0;
        tick(6);
        check(32'(sysfail_output), 32'h1);
        apb(1'b1, `OFS_CRCSR_BIT_CLEAR, 32'h1);
        tick(4);
        check(32'(sysfail_output), 32'h0);
        board_fail_input_b <= 1'b1;
        apb(1'b1, `OFS_GENERAL_CONTROL, 32'h3);
        tick(4);
        check(32'(sysfail_output), 32'h1);
        apb(1'b1, `OFS_GENERAL_CONTROL, 32'h2);
        apb(1'b1, `OFS_CRCSR_BIT_SET, 32'h1);
        apb(1'b0, `OFS_GENERAL_CONTROL, 32'h0);
        check(rd, 32'h3);
        apb(1'b1, `OFS_CRCSR_ATTRIBUTE, 32'h0);
        apb(1'b1, `OFS_CRCSR_BASE, 32'h18);
        sysrst;
        check(32'(crcsr_enable), 32'h1);
        check(32'(crcsr_base_bits), 32'h15);
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], er}, 32'h1);
        powerup(4'b1100, 5'b00111, 3'b011);
        check(32'(crcsr_base_bits), 32'h18);
        $display("test geo done");
    endtask
    task automatic t_straps;
        logic [2:0] sc [5] = '{3'b000, 3'b010, 3'b101, 3'b110, 3'b111};
        for (int i = 0; i < 5; i++) begin
            powerup({3'b000, i[0]}, 5'h0a, sc[i]);
            check(32'(system_controller_function), 32'(i == 1 || i == 3));
            check(32'({crcsr_enable, crcsr_base_bits}), 32'h0);
            apb(1'b0, `OFS_GENERAL_CONTROL, 32'h0);
            check(rd, 32'(i[0]));
        end
        $display("test straps done");
    endtask
    // software leaves the enable alone throughout, as the monarch would wait for release
    task automatic t_auto(input logic [3:0] c, input logic ac);
        powerup(c, 5'h1f, 3'b011);
        sysrst;
        check(32'({crcsr_enable, crcsr_base_bits}), 32'h0);
        check(32'(irq2_request), 32'h1);
        check(32'(sysfail_output), 32'h1);
        tick(30);
        check(32'(sysfail_output), 32'(!ac));
        apb(1'b1, `OFS_VME_CONTROL, 32'h0);
        tick(4);
        check(32'(sysfail_output), 32'h0);
        apb(1'b1, `OFS_CRCSR_BASE, 32'h08);
        check(32'(irq2_request), 32'h0);
        $display("test auto slot done");
    endtask
    initial begin
        tick(8);
        rst_b <= 1'b1;
        tick(2);
        t_geo;
        t_straps;
        t_auto(4'b0110, 1'b1);
        t_auto(4'b1100, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
